// *** shared/scan_cfg_pkg.sv ***
package scan_cfg_pkg;

  // Instruction register
  localparam int IR_LEN = 10;
  localparam logic [IR_LEN-1:0] IR_CAPTURE_VAL = 10'h001;
  localparam logic [IR_LEN-1:0] BYPASS_INSTR = 10'h3ff;
  localparam logic [IR_LEN-1:0] CFG_LOAD_INSTR = 10'h3c5;
  localparam logic [IR_LEN-1:0] SCAN_STARTUP_INSTR = 10'h3cc;
  localparam logic [IR_LEN-1:0] SCAN_SHUTDOWN_INSTR = 10'h3cd;
  localparam logic [IR_LEN-1:0] INSYS_ENABLE_INSTR = 10'h3d0;
  localparam logic [IR_LEN-1:0] INSYS_DISABLE_INSTR = 10'h3d6;

  // User scan ports and the user instruction each one answers to
  localparam int USER_PORTS = 4;
  localparam logic [USER_PORTS-1:0][IR_LEN-1:0] USER_SCAN_INSTR = {10'h3e3, 10'h3e2, 10'h3c3, 10'h3c2};

  // Configuration word stream, MSB first
  localparam int WORD_LEN = 32;
  localparam int WCNT_W = 5;
  localparam logic [WCNT_W-1:0] WCNT_LAST = 5'h1f;
  localparam logic [WORD_LEN-1:0] SYNC_WORD = 32'h5a3c_96e1;
  localparam logic [WORD_LEN-1:0] CRC_RESET_CMD = 32'h3000_8007;
  localparam logic [WORD_LEN-1:0] ASSERT_GLOBAL_HOLD_CMD = 32'h3000_8008;

  // Startup sequence length in test clocks
  localparam int PHASE_W = 4;
  localparam logic [PHASE_W-1:0] PHASE_IDLE = 4'h0;
  localparam logic [PHASE_W-1:0] PHASE_LAST = 4'hc;
  localparam logic [PHASE_W-1:0] PHASE_ONE = 4'h1;

  // Synchroniser depth
  localparam int SYNC_STAGES = 2;

  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SH_DR = 4'h4, EX1_DR = 4'h5, PA_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'ha, SH_IR = 4'hb,
    EX1_IR = 4'hc, PA_IR = 4'hd, EX2_IR = 4'he, UPD_IR = 4'hf
  } tap_state_e;

  typedef enum logic [1:0] {
    UNPROG = 2'h0,
    ACCESSED = 2'h1,
    COMPLETE = 2'h2,
    OPERATIONAL = 2'h3
  } isc_state_e;

endpackage

// *** hdl/level_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

// Two-stage level synchroniser; first stage feeds only the second
module level_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_q;

  // Reset drives constants only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= RESET_VAL;
      q <= RESET_VAL;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end

endmodule // level_sync

`default_nettype wire

// *** hdl/scan_cfg_ctrl.sv ***
// Functional notes
// - Reconfiguration over scan never clears stored configuration; only the clear pin does.
// - Clean reconfiguration needs a clear-pin pulse or a completed shutdown sequence first.
// - After power-up the device is unprogrammed with user I/O inactive.
// - Running in-system enable sets the enabled flag and enters the accessed state.
// - Leaving operational for accessed runs shutdown, making user I/O inactive.
// - Startup runs in accessed; at its end enabled clears and state becomes complete.
// - Done flag rises only when CRC and configuration error status are clean.
// - Complete goes to operational with done set, else back to unprogrammed.
// - Test-logic-reset in accessed with done set goes straight to operational.
// - Operational reached that way keeps I/O inactive until startup runs there.
// - Startup and shutdown are clocked only by the test clock here.
// - Startup steps only on idle clocks under in-system disable (in accessed) or scan startup; host supplies them.
// - Shutdown steps backwards on idle clocks under in-system enable; host supplies them.
// - Four user scan ports, each bound to its own user instruction.
// - Port select is high while its instruction is held, updated falling edge update-IR.
// - User reset high in test-logic-reset, clear and power-up; released on falling edge.
// - Data input passes straight through; gated clock follows test clock in capture/shift.
// - Capture, shift and update indications follow their states on falling edges.
// - User scan output is sampled on the falling edge before driving the data pin.
`timescale 1ns/1ps
`default_nettype none

module scan_cfg_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic cfg_clear_n,
  input wire logic crc_error,
  input wire logic config_error,
  output logic crc_reset_req,
  output logic global_interconnect_hold_n,
  output logic [1:0] isc_state,
  output logic [3:0] user_sel,
  output logic [3:0] user_dr_gated_clock,
  output logic user_reset,
  output logic user_capture,
  output logic user_shift,
  output logic user_update,
  output logic user_tdi,
  input wire logic [3:0] user_tdo,
  output logic insys_done_flag,
  output logic insys_enabled_flag,
  output logic user_io_active
);

  scan_cfg_pkg::tap_state_e tap_q;
  scan_cfg_pkg::isc_state_e isc_q;
  logic [scan_cfg_pkg::IR_LEN-1:0] ir_sh_q;
  logic [scan_cfg_pkg::IR_LEN-1:0] ir_q;
  logic bypass_q;
  logic [scan_cfg_pkg::WORD_LEN-1:0] word_q;
  logic [scan_cfg_pkg::WORD_LEN-1:0] word_d;
  logic [scan_cfg_pkg::WCNT_W-1:0] wcnt_q;
  logic synced_q;
  logic [scan_cfg_pkg::PHASE_W-1:0] phase_q;
  logic enabled_q;
  logic done_q;
  logic io_active_q;
  logic dr_clk_en_q;
  logic [1:0] status_s;
  logic clear_n_s;
  logic clr;
  logic status_ok;
  logic rti;
  logic cfg_dr;
  logic word_hit;
  logic up_go;
  logic dn_go;
  logic en_go;
  logic last_up;

  // Standard next-state table of the port controller
  function automatic scan_cfg_pkg::tap_state_e tap_next(input scan_cfg_pkg::tap_state_e s, input logic m);
    case (s)
      scan_cfg_pkg::TLR: tap_next = m ? scan_cfg_pkg::TLR : scan_cfg_pkg::RTI;
      scan_cfg_pkg::RTI: tap_next = m ? scan_cfg_pkg::SEL_DR : scan_cfg_pkg::RTI;
      scan_cfg_pkg::SEL_DR: tap_next = m ? scan_cfg_pkg::SEL_IR : scan_cfg_pkg::CAP_DR;
      scan_cfg_pkg::CAP_DR: tap_next = m ? scan_cfg_pkg::EX1_DR : scan_cfg_pkg::SH_DR;
      scan_cfg_pkg::SH_DR: tap_next = m ? scan_cfg_pkg::EX1_DR : scan_cfg_pkg::SH_DR;
      scan_cfg_pkg::EX1_DR: tap_next = m ? scan_cfg_pkg::UPD_DR : scan_cfg_pkg::PA_DR;
      scan_cfg_pkg::PA_DR: tap_next = m ? scan_cfg_pkg::EX2_DR : scan_cfg_pkg::PA_DR;
      scan_cfg_pkg::EX2_DR: tap_next = m ? scan_cfg_pkg::UPD_DR : scan_cfg_pkg::SH_DR;
      scan_cfg_pkg::UPD_DR: tap_next = m ? scan_cfg_pkg::SEL_DR : scan_cfg_pkg::RTI;
      scan_cfg_pkg::SEL_IR: tap_next = m ? scan_cfg_pkg::TLR : scan_cfg_pkg::CAP_IR;
      scan_cfg_pkg::CAP_IR: tap_next = m ? scan_cfg_pkg::EX1_IR : scan_cfg_pkg::SH_IR;
      scan_cfg_pkg::SH_IR: tap_next = m ? scan_cfg_pkg::EX1_IR : scan_cfg_pkg::SH_IR;
      scan_cfg_pkg::EX1_IR: tap_next = m ? scan_cfg_pkg::UPD_IR : scan_cfg_pkg::PA_IR;
      scan_cfg_pkg::PA_IR: tap_next = m ? scan_cfg_pkg::EX2_IR : scan_cfg_pkg::PA_IR;
      scan_cfg_pkg::EX2_IR: tap_next = m ? scan_cfg_pkg::UPD_IR : scan_cfg_pkg::SH_IR;
      default: tap_next = m ? scan_cfg_pkg::SEL_DR : scan_cfg_pkg::RTI;
    endcase
  endfunction

  // Crossings: error status and clear pin into the test clock domain
  level_sync #(.WIDTH(2), .RESET_VAL(2'h0)) u_status_sync (
    .clk(tck),
    .rst(sys_rst),
    .d({crc_error, config_error}),
    .q(status_s)
  );

  level_sync #(.WIDTH(1), .RESET_VAL(1'h0)) u_clear_sync (
    .clk(tck),
    .rst(sys_rst),
    .d(cfg_clear_n),
    .q(clear_n_s)
  );

  // Flags out to the system clock domain, one level each
  level_sync #(.WIDTH(3), .RESET_VAL(3'h0)) u_flag_sync (
    .clk(clk),
    .rst(sys_rst),
    .d({done_q, enabled_q, io_active_q}),
    .q({insys_done_flag, insys_enabled_flag, user_io_active})
  );

  // Clear held low at reset release reads as a clear, which is harmless
  assign clr = ~clear_n_s;
  assign status_ok = ~status_s[1] & ~status_s[0];
  assign rti = (tap_q == scan_cfg_pkg::RTI);
  assign cfg_dr = (tap_q == scan_cfg_pkg::SH_DR) && (ir_q == scan_cfg_pkg::CFG_LOAD_INSTR);
  assign word_d = {word_q[scan_cfg_pkg::WORD_LEN-2:0], tdi};
  assign word_hit = cfg_dr && synced_q && (wcnt_q == scan_cfg_pkg::WCNT_LAST);

  // Sequencer steps run on the test clock only, so no other clock is needed
  assign up_go = rti && (phase_q != scan_cfg_pkg::PHASE_LAST) &&
                 (((ir_q == scan_cfg_pkg::INSYS_DISABLE_INSTR) && (isc_q == scan_cfg_pkg::ACCESSED)) ||
                  (ir_q == scan_cfg_pkg::SCAN_STARTUP_INSTR));
  assign dn_go = rti && (phase_q != scan_cfg_pkg::PHASE_IDLE) &&
                 (((ir_q == scan_cfg_pkg::INSYS_ENABLE_INSTR) && (isc_q == scan_cfg_pkg::ACCESSED)) ||
                  (ir_q == scan_cfg_pkg::SCAN_SHUTDOWN_INSTR));
  assign en_go = rti && (ir_q == scan_cfg_pkg::INSYS_ENABLE_INSTR) && (isc_q != scan_cfg_pkg::ACCESSED);
  assign last_up = up_go && (phase_q == scan_cfg_pkg::PHASE_LAST - scan_cfg_pkg::PHASE_ONE);

  // Port controller state
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      tap_q <= scan_cfg_pkg::TLR;
    end else begin
      tap_q <= tap_next(tap_q, tms);
    end
  end

  // Instruction shift path, LSB first
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      ir_sh_q <= scan_cfg_pkg::IR_CAPTURE_VAL;
    end else if (tap_q == scan_cfg_pkg::CAP_IR) begin
      ir_sh_q <= scan_cfg_pkg::IR_CAPTURE_VAL;
    end else if (tap_q == scan_cfg_pkg::SH_IR) begin
      ir_sh_q <= {tdi, ir_sh_q[scan_cfg_pkg::IR_LEN-1:1]};
    end
  end

  // Bypass bit for any instruction without its own data path
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      bypass_q <= 1'h0;
    end else if (tap_q == scan_cfg_pkg::CAP_DR) begin
      bypass_q <= 1'h0;
    end else if (tap_q == scan_cfg_pkg::SH_DR) begin
      bypass_q <= tdi;
    end
  end

  // Active instruction and port selects change on the falling edge
  always_ff @(negedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      ir_q <= scan_cfg_pkg::BYPASS_INSTR;
    end else if (tap_q == scan_cfg_pkg::TLR) begin
      ir_q <= scan_cfg_pkg::BYPASS_INSTR;
    end else if (tap_q == scan_cfg_pkg::UPD_IR) begin
      ir_q <= ir_sh_q;
    end
  end

  // One select per user port, bound by its chain code
  for (genvar i = 0; i < scan_cfg_pkg::USER_PORTS; i++) begin : g_user
    always_ff @(negedge tck or posedge sys_rst) begin
      if (sys_rst) begin
        user_sel[i] <= 1'h0;
      end else if (tap_q == scan_cfg_pkg::TLR) begin
        user_sel[i] <= 1'h0;
      end else if (tap_q == scan_cfg_pkg::UPD_IR) begin
        user_sel[i] <= (ir_sh_q == scan_cfg_pkg::USER_SCAN_INSTR[i]);
      end
    end

    // Gated data clock: the test clock itself is the only glitch-free source
    assign user_dr_gated_clock[i] = ~(user_sel[i] & dr_clk_en_q) | tck;

    // Select and instruction move on the same falling edge, so they agree at every rising edge
    property p_sel_tracks_ir;
      @(posedge tck) disable iff (sys_rst) user_sel[i] == (ir_q == scan_cfg_pkg::USER_SCAN_INSTR[i]);
    endproperty
    a_sel_tracks_ir: assert property (p_sel_tracks_ir) else $error("user select disagrees with instruction");
  end

  // Data input reaches user logic with no register in the way
  assign user_tdi = tdi;

  // Falling-edge indications toward user logic
  always_ff @(negedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      user_reset <= 1'h1;
      user_capture <= 1'h0;
      user_shift <= 1'h0;
      user_update <= 1'h0;
      dr_clk_en_q <= 1'h0;
    end else begin
      user_reset <= (tap_q == scan_cfg_pkg::TLR) || clr;
      user_capture <= (tap_q == scan_cfg_pkg::CAP_DR);
      user_shift <= (tap_q == scan_cfg_pkg::SH_DR);
      user_update <= (tap_q == scan_cfg_pkg::UPD_DR);
      dr_clk_en_q <= (tap_q == scan_cfg_pkg::CAP_DR) || (tap_q == scan_cfg_pkg::SH_DR);
    end
  end

  // Data pin out: user output is sampled right at this edge
  always_ff @(negedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      tdo_o <= 1'h0;
      tdo_oe <= 1'h0;
    end else begin
      tdo_oe <= (tap_q == scan_cfg_pkg::SH_IR) || (tap_q == scan_cfg_pkg::SH_DR);
      if (tap_q == scan_cfg_pkg::SH_IR) begin
        tdo_o <= ir_sh_q[0];
      end else if (|user_sel) begin
        tdo_o <= |(user_sel & user_tdo);
      end else if (ir_q == scan_cfg_pkg::CFG_LOAD_INSTR) begin
        tdo_o <= word_q[scan_cfg_pkg::WORD_LEN-1];
      end else begin
        tdo_o <= bypass_q;
      end
    end
  end

  // Configuration word framing; stored state survives port resets
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      word_q <= '0;
      wcnt_q <= '0;
      synced_q <= 1'h0;
    end else if (clr) begin
      synced_q <= 1'h0;
      wcnt_q <= '0;
    end else if (cfg_dr) begin
      word_q <= word_d;
      if (!synced_q && (word_d == scan_cfg_pkg::SYNC_WORD)) begin
        synced_q <= 1'h1;
        wcnt_q <= '0;
      end else if (synced_q) begin
        wcnt_q <= wcnt_q + 5'h01;
      end
    end
  end

  // CRC reset request, one test clock wide
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      crc_reset_req <= 1'h0;
    end else begin
      crc_reset_req <= word_hit && (word_d == scan_cfg_pkg::CRC_RESET_CMD);
    end
  end

  // Global hold: set by command or by shutdown, released by a clean startup
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      global_interconnect_hold_n <= 1'h0;
    end else if (clr) begin
      global_interconnect_hold_n <= 1'h0;
    end else if (word_hit && (word_d == scan_cfg_pkg::ASSERT_GLOBAL_HOLD_CMD)) begin
      global_interconnect_hold_n <= 1'h0;
    end else if (dn_go && (phase_q == scan_cfg_pkg::PHASE_ONE)) begin
      global_interconnect_hold_n <= 1'h0;
    end else if (last_up && status_ok) begin
      global_interconnect_hold_n <= 1'h1;
    end
  end

  // Startup position: forward for startup, backward for shutdown
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= scan_cfg_pkg::PHASE_IDLE;
    end else if (clr) begin
      phase_q <= scan_cfg_pkg::PHASE_IDLE;
    end else if (up_go) begin
      phase_q <= phase_q + scan_cfg_pkg::PHASE_ONE;
    end else if (dn_go) begin
      phase_q <= phase_q - scan_cfg_pkg::PHASE_ONE;
    end
  end

  // In-system modal state, enabled and done flags
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      isc_q <= scan_cfg_pkg::UNPROG;
      enabled_q <= 1'h0;
      done_q <= 1'h0;
    end else if (clr) begin
      isc_q <= scan_cfg_pkg::UNPROG;
      enabled_q <= 1'h0;
      done_q <= 1'h0;
    end else if (en_go) begin
      isc_q <= scan_cfg_pkg::ACCESSED;
      enabled_q <= 1'h1;
    end else begin
      case (isc_q)
        scan_cfg_pkg::ACCESSED: begin
          if (last_up) begin
            done_q <= status_ok;
            if (ir_q == scan_cfg_pkg::INSYS_DISABLE_INSTR) begin
              enabled_q <= 1'h0;
              isc_q <= scan_cfg_pkg::COMPLETE;
            end else if (status_ok) begin
              isc_q <= scan_cfg_pkg::OPERATIONAL;
            end
          end else if ((tap_q == scan_cfg_pkg::TLR) && done_q) begin
            isc_q <= scan_cfg_pkg::OPERATIONAL;
          end
        end
        scan_cfg_pkg::COMPLETE: begin
          isc_q <= done_q ? scan_cfg_pkg::OPERATIONAL : scan_cfg_pkg::UNPROG;
        end
        default: begin
          // Plain scan startup outside the in-system flow
          if (last_up) begin
            done_q <= status_ok;
            if (status_ok) begin
              isc_q <= scan_cfg_pkg::OPERATIONAL;
            end
          end
        end
      endcase
    end
  end

  // User I/O live only after a full startup while operational
  always_ff @(posedge tck or posedge sys_rst) begin
    if (sys_rst) begin
      io_active_q <= 1'h0;
    end else begin
      io_active_q <= (phase_q == scan_cfg_pkg::PHASE_LAST) && done_q &&
                     (isc_q == scan_cfg_pkg::OPERATIONAL) && !clr;
    end
  end

  assign isc_state = isc_q;

  // Checks on the test clock domain
  sequence s_five_ones;
    tms [*5];
  endsequence

  sequence s_enable_taken;
    en_go && !clr;
  endsequence

  property p_five_ones_reset;
    @(posedge tck) disable iff (sys_rst) s_five_ones |=> (tap_q == scan_cfg_pkg::TLR);
  endproperty
  a_five_ones_reset: assert property (p_five_ones_reset) else $error("five ones did not reset port");

  property p_enable_access;
    @(posedge tck) disable iff (sys_rst) s_enable_taken |=> (isc_q == scan_cfg_pkg::ACCESSED) && enabled_q;
  endproperty
  a_enable_access: assert property (p_enable_access) else $error("enable did not reach accessed");

  property p_complete_clears_enabled;
    @(posedge tck) disable iff (sys_rst) $rose(isc_q == scan_cfg_pkg::COMPLETE) |-> !enabled_q;
  endproperty
  a_complete_clears_enabled: assert property (p_complete_clears_enabled) else $error("enabled still set");

  property p_done_needs_status;
    @(posedge tck) disable iff (sys_rst) $rose(done_q) |-> $past(status_ok) && $past(last_up);
  endproperty
  a_done_needs_status: assert property (p_done_needs_status) else $error("done rose without clean status");

  property p_complete_exit;
    @(posedge tck) disable iff (sys_rst)
      (isc_q == scan_cfg_pkg::COMPLETE) && !clr && !en_go |=>
      (isc_q == ($past(done_q) ? scan_cfg_pkg::OPERATIONAL : scan_cfg_pkg::UNPROG));
  endproperty
  a_complete_exit: assert property (p_complete_exit) else $error("wrong exit from complete");

  property p_tlr_shortcut;
    @(posedge tck) disable iff (sys_rst)
      (tap_q == scan_cfg_pkg::TLR) && (isc_q == scan_cfg_pkg::ACCESSED) && done_q && !clr && !last_up |=>
      (isc_q == scan_cfg_pkg::OPERATIONAL) ##1 !io_active_q;
  endproperty
  a_tlr_shortcut: assert property (p_tlr_shortcut) else $error("reset shortcut misbehaved");

  property p_shutdown_steps_back;
    @(posedge tck) disable iff (sys_rst) dn_go && !up_go && !clr |=> (phase_q == $past(phase_q) - 4'h1);
  endproperty
  a_shutdown_steps_back: assert property (p_shutdown_steps_back) else $error("shutdown did not step back");

  property p_startup_only_idle;
    @(posedge tck) disable iff (sys_rst) (phase_q > $past(phase_q)) |-> $past(rti);
  endproperty
  a_startup_only_idle: assert property (p_startup_only_idle) else $error("startup stepped outside idle");

  property p_reset_in_tlr;
    @(posedge tck) disable iff (sys_rst) (tap_q == scan_cfg_pkg::TLR) |-> user_reset;
  endproperty
  a_reset_in_tlr: assert property (p_reset_in_tlr) else $error("user reset low in reset state");

  property p_shift_marks;
    @(posedge tck) disable iff (sys_rst) (tap_q == scan_cfg_pkg::SH_DR) |-> user_shift && !user_capture;
  endproperty
  a_shift_marks: assert property (p_shift_marks) else $error("shift indication wrong");

endmodule // scan_cfg_ctrl

`default_nettype wire

// *** verif/scan_host.sv ***
`timescale 1ns/1ps
`default_nettype none

// Scan host; test clock stands low between steps
module scan_host (
  output logic tck,
  output logic tms,
  output logic tdi
);
  // Idle pins at time zero
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock; pins change just after the falling edge
  task automatic step(input logic m, input logic d);
    #1;
    tms = m;
    tdi = d;
    #15;
    tck = 1'b1;
    #16;
    tck = 1'b0;
  endtask

  // Five ones force test-logic-reset
  task automatic reset_tap();
    repeat (5) step(1'b1, ~tdi);
  endtask

  // Idle clocks in run-test/idle, toggling tdi so no stale level lingers
  task automatic idle(input int n);
    repeat (n) step(1'b0, ~tdi);
  endtask

  // Instruction LSB first, ends back in run-test/idle
  task automatic load_ir(input logic [9:0] code);
    step(1'b1, ~tdi);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 0; i < 10; i++) step(i == 9, code[i]);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask

  // Two config words MSB first in one data scan
  task automatic shift_dr(input logic [63:0] v);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
    step(1'b0, ~tdi);
    for (int i = 63; i >= 0; i--) step(i == 0, v[i]);
    step(1'b1, ~tdi);
    step(1'b0, ~tdi);
  endtask
endmodule // scan_host

`default_nettype wire

// *** verif/jtag_config_isc_user_scan_test.sv ***
`timescale 1ns/1ps
`default_nettype none

module jtag_config_isc_user_scan_test;
  logic clk, sys_rst, tck, tms, tdi, tdo_o, tdo_oe, cfg_clear_n, crc_error, config_error;
  logic crc_reset_req, hold_n, user_reset, user_capture, user_shift, user_update, user_tdi;
  logic done, enabled, io_act, crc_seen;
  logic [1:0] isc_state;
  logic [3:0] user_sel, user_dr_gated_clock, user_tdo;
  int mismatches = 0;
  int checks = 0;
  int seed = 99371;

  scan_host host (.tck(tck), .tms(tms), .tdi(tdi));
  scan_cfg_ctrl dut (.clk(clk), .sys_rst(sys_rst), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o),
    .tdo_oe(tdo_oe), .cfg_clear_n(cfg_clear_n), .crc_error(crc_error), .config_error(config_error),
    .crc_reset_req(crc_reset_req), .global_interconnect_hold_n(hold_n), .isc_state(isc_state),
    .user_sel(user_sel), .user_dr_gated_clock(user_dr_gated_clock), .user_reset(user_reset), .user_capture(user_capture),
    .user_shift(user_shift), .user_update(user_update), .user_tdi(user_tdi), .user_tdo(user_tdo),
    .insys_done_flag(done), .insys_enabled_flag(enabled), .user_io_active(io_act));

  // System clock, 4 ns
  always #2 clk = ~clk;

  // Pulse is one test clock wide, so keep a sticky copy
  always @(posedge crc_reset_req) crc_seen = 1'b1;

  task automatic check_bit(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %b seen %b", n, e, g);
    end
  endtask

  task automatic check_vec(input string n, input logic [3:0] e, input logic [3:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  // Flags cross into the system clock domain
  task automatic settle();
    repeat (10) @(posedge clk);
    #1;
  endtask

  function automatic logic exp_done(input logic c, input logic f);
    return !(c | f);
  endfunction

  function automatic logic [3:0] sel_mask(input int p);
    return 4'h1 << p;
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Walk one user port through capture, shift and update
  task automatic user_port(input int p);
    logic d_bit;
    host.load_ir(scan_cfg_pkg::USER_SCAN_INSTR[p]);
    #2 check_vec("user_sel", sel_mask(p), user_sel);
    host.step(1'b1, $random(seed));
    host.step(1'b0, $random(seed));
    #2 check_bit("user_capture", 1'b1, user_capture);
    user_tdo = $random(seed);
    d_bit = $random(seed);
    host.step(1'b0, d_bit);
    #2 check_bit("user_shift", 1'b1, user_shift);
    check_bit("tdo_o", user_tdo[p], tdo_o);
    check_bit("tdo_oe", 1'b1, tdo_oe);
    check_vec("user_dr_gated_clock", ~sel_mask(p), user_dr_gated_clock);
    check_bit("user_tdi", d_bit, user_tdi);
    host.step(1'b1, $random(seed));
    host.step(1'b1, $random(seed));
    #2 check_bit("user_update", 1'b1, user_update);
    host.step(1'b0, 1'b0);
  endtask

  // Hang guard
  initial begin
    #300000;
    mismatches++;
    complete_run();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    cfg_clear_n = 1'b1;
    crc_error = 1'b0;
    config_error = 1'b0;
    user_tdo = 4'h0;
    crc_seen = 1'b0;
    fork
      begin
        repeat (12) @(posedge clk);
        #1 sys_rst = 1'b0;
      end
      host.step(1'b1, 1'b0);
    join
    check_vec("isc_state", scan_cfg_pkg::UNPROG, isc_state);
    check_bit("user_reset", 1'b1, user_reset);
    host.reset_tap();
    host.step(1'b0, 1'b0);
    #2 check_bit("user_reset", 1'b0, user_reset);
    // Enable, then a clean startup
    host.load_ir(scan_cfg_pkg::INSYS_ENABLE_INSTR);
    host.idle(1);
    #2 check_vec("isc_state", scan_cfg_pkg::ACCESSED, isc_state);
    settle();
    check_bit("enabled", 1'b1, enabled);
    host.load_ir(scan_cfg_pkg::INSYS_DISABLE_INSTR);
    host.idle(11);
    #2 check_vec("isc_state", scan_cfg_pkg::ACCESSED, isc_state);
    host.idle(1);
    #2 check_vec("isc_state", scan_cfg_pkg::COMPLETE, isc_state);
    host.idle(2);
    #2 check_vec("isc_state", scan_cfg_pkg::OPERATIONAL, isc_state);
    settle();
    check_bit("enabled", 1'b0, enabled);
    check_bit("done", exp_done(1'b0, 1'b0), done);
    check_bit("io_active", 1'b1, io_act);
    check_bit("hold_n", 1'b1, hold_n);
    // Port reset in accessed with done set
    host.load_ir(scan_cfg_pkg::INSYS_ENABLE_INSTR);
    host.idle(1);
    #2 check_vec("isc_state", scan_cfg_pkg::ACCESSED, isc_state);
    host.reset_tap();
    #2 check_vec("isc_state", scan_cfg_pkg::OPERATIONAL, isc_state);
    host.step(1'b0, 1'b0);
    settle();
    check_bit("io_active", 1'b0, io_act);
    host.load_ir(scan_cfg_pkg::SCAN_STARTUP_INSTR);
    host.idle(13);
    settle();
    check_bit("io_active", 1'b1, io_act);
    // Full shutdown: one idle clock enters accessed, twelve more count all phases down
    host.load_ir(scan_cfg_pkg::INSYS_ENABLE_INSTR);
    host.idle(13);
    settle();
    check_bit("hold_n", 1'b0, hold_n);
    check_bit("io_active", 1'b0, io_act);
    host.load_ir(scan_cfg_pkg::CFG_LOAD_INSTR);
    host.shift_dr({scan_cfg_pkg::SYNC_WORD, scan_cfg_pkg::CRC_RESET_CMD});
    check_bit("crc_reset_req", 1'b1, crc_seen);
    // Startups: a failing corner, a clean corner, then random status; each after a full shutdown
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        host.load_ir(scan_cfg_pkg::INSYS_ENABLE_INSTR);
        host.idle(13);
        check_bit("hold_n", 1'b0, hold_n);
      end
      @(posedge clk);
      #1 {crc_error, config_error} = (k > 1) ? 2'($random(seed)) : ((k == 0) ? 2'h2 : 2'h0);
      settle();
      host.load_ir(scan_cfg_pkg::INSYS_DISABLE_INSTR);
      host.idle(14);
      #2 check_vec("isc_state", exp_done(crc_error, config_error) ? 4'h3 : 4'h0, isc_state);
      check_bit("hold_n", exp_done(crc_error, config_error), hold_n);
      settle();
      check_bit("done", exp_done(crc_error, config_error), done);
    end
    for (int p = 0; p < 4; p++) user_port(p);
    host.load_ir(scan_cfg_pkg::BYPASS_INSTR);
    #2 check_vec("user_sel", 4'h0, user_sel);
    // Clear pin wins over everything
    @(posedge clk);
    #1 cfg_clear_n = 1'b0;
    host.idle(3);
    #2 check_vec("isc_state", scan_cfg_pkg::UNPROG, isc_state);
    check_bit("user_reset", 1'b1, user_reset);
    cfg_clear_n = 1'b1;
    host.idle(3);
    complete_run();
  end
endmodule // jtag_config_isc_user_scan_test

`default_nettype wire
